/* File: src/uart_rx_consts.svh */
// Constants for the asynchronous serial receiver
//
// Functional notes
// - Line sampled at sixteen ticks per bit; shift register advances once per bit.
// - Characters carry eight or nine data bits before being handed on.
// - Finished characters go straight into a two-entry FIFO.
// - Shift register and FIFO only reachable through the receive data register.
// - Receiver runs only with receive enable 1, clocked mode 0, port enable 1.
// - Reception starts on a falling edge of the line, the zero start bit.
// - Half a bit later recheck; if line high, drop silently and rearm.
// - Full bit time to each bit centre, majority vote, shift voted bit in.
// - Stop position sampled a bit later; zero sets framing error, else clears.
// - Right after stop bit, character enters FIFO and pending flag rises.
// - Reading receive data returns and removes the oldest character.
// - After an overrun no characters accepted until overrun is cleared.
// - Pending flag high while enabled with unread data; software cannot touch it.
// - Interrupt only when receive, peripheral and global enables and pending all set.
// - Pending flag ignores every interrupt enable.
// - Wide high-speed mode bit rate is clock over four times divisor plus one.
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH

`define RX_REG_CTRL    4'h0
`define RX_REG_BAUD    4'h1
`define RX_REG_DATA    4'h2
`define RX_REG_STATUS  4'h3
`define RX_REG_IRQEN   4'h4

`define CTRL_RX_EN     0
`define CTRL_SYNC      1
`define CTRL_PORT_EN   2
`define CTRL_NINE      3
`define CTRL_HISPEED   4
`define CTRL_WIDE      5

`define STAT_PENDING   0
`define STAT_OVERRUN   1
`define STAT_FRAMING   2
`define STAT_NINTH     3

`define IRQ_RX_EN      0
`define IRQ_PERIPH_EN  1
`define IRQ_GLOBAL_EN  2

`define CTRL_RESET     6'h00
`define BAUD_RESET     16'h0000
`define OVERSAMPLE     16
`define FIFO_DEPTH     2

`endif

/* File: src/uart_rx_pkg.sv */
// Types for the asynchronous serial receiver
package uart_rx_pkg;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rxState_t;

  typedef struct packed {
    logic       framing;
    logic [8:0] data;
  } rxChar_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } regReq_t;

endpackage : uart_rx_pkg

/* File: src/uart_rx_fifo.sv */
// Two-entry character store with registered read data
`timescale 1ns/10ps
`default_nettype none

module uart_rx_fifo #(
  parameter int DEPTH = 2
) (
  input  wire logic               clk,
  input  wire logic               rstN,
  input  wire logic               flush,
  input  wire logic               push,
  input  wire uart_rx_pkg::rxChar_t pushData,
  input  wire logic               pop,
  output var  uart_rx_pkg::rxChar_t headQ,
  output logic                    full,
  output logic                    empty
);

  typedef struct packed {
    uart_rx_pkg::rxChar_t [DEPTH-1:0] mem;
    logic [1:0]                       rdPtr;
    logic [1:0]                       wrPtr;
    logic [1:0]                       count;
    uart_rx_pkg::rxChar_t             head;
  } fifoState_t;

  fifoState_t sQ;
  fifoState_t sD;
  logic       doPush;
  logic       doPop;
  logic [1:0] nextRd;

  assign full  = (sQ.count == 2'(DEPTH));
  assign empty = (sQ.count == 2'h0);
  assign headQ = sQ.head;

  always_comb begin
    sD     = sQ;
    doPush = push && !full;
    doPop  = pop && !empty;
    nextRd = (sQ.rdPtr == 2'(DEPTH - 1)) ? 2'h0 : sQ.rdPtr + 2'h1;
    if (doPush) begin
      sD.mem[sQ.wrPtr] = pushData;
      sD.wrPtr = (sQ.wrPtr == 2'(DEPTH - 1)) ? 2'h0 : sQ.wrPtr + 2'h1;
    end
    if (doPop) begin
      sD.rdPtr = nextRd;
    end
    sD.count = sQ.count + {1'b0, doPush} - {1'b0, doPop};
    // Head register is loaded with the next state's oldest entry so the read port sees it with no extra cycle
    if (sD.count == 2'h0) begin
      sD.head = '0;
    end else if (sD.rdPtr == sQ.wrPtr && doPush) begin
      sD.head = pushData;
    end else begin
      sD.head = sQ.mem[sD.rdPtr];
    end
    if (flush) begin
      sD = '0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sQ <= '0;
    end else begin
      sQ <= sD;
    end
  end

endmodule : uart_rx_fifo

`default_nettype wire

/* File: src/async_uart_receiver.sv */
// Asynchronous serial receiver with 16x oversampling and register port
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "uart_rx_consts.svh"

module async_uart_receiver (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        rxPin,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output var  logic [15:0] regRdata,
  output logic             rxIrq
);

  typedef struct packed {
    logic [5:0]            ctrl;
    logic [15:0]           baud;
    logic [2:0]            irqEn;
    uart_rx_pkg::rxState_t state;
    logic [15:0]           tickCnt;
    logic [3:0]            phase;
    logic [3:0]            bitCnt;
    logic [8:0]            shift;
    logic [2:0]            votes;
    logic                  rxPrev;
    logic                  overrun;
    logic                  framing;
    logic                  ninth;
    logic [15:0]           rdata;
  } rxTop_t;

  rxTop_t sQ;
  rxTop_t sD;
  logic [1:0]  rstSyncQ;
  logic [16:0] divPlus;
  logic [14:0] tickLen;
  logic [15:0] tickReload;
  logic   rstN;
  logic   active;
  logic   tick;
  logic   fifoPush;
  logic   fifoPop;
  logic   fifoFull;
  logic   fifoEmpty;
  logic   pending;
  logic   majority;
  uart_rx_pkg::rxChar_t pushChar;
  uart_rx_pkg::rxChar_t headChar;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  // Kept out of the state struct: it lives in the raw reset domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSyncQ <= 2'h0;
    end else begin
      rstSyncQ <= {rstSyncQ[0], 1'b1};
    end
  end
  assign rstN = rstSyncQ[1];

  function automatic logic vote3(input logic [2:0] v);
    vote3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction : vote3

  assign active = sQ.ctrl[`CTRL_RX_EN] && !sQ.ctrl[`CTRL_SYNC] && sQ.ctrl[`CTRL_PORT_EN];
  assign pending = sQ.ctrl[`CTRL_RX_EN] && !fifoEmpty;
  assign rxIrq = pending && sQ.irqEn[`IRQ_RX_EN] && sQ.irqEn[`IRQ_PERIPH_EN]
                 && sQ.irqEn[`IRQ_GLOBAL_EN];
  assign majority = vote3({sQ.votes[1:0], rxPin});

  // ------------------------------------------------------------
  // Oversampling tick: one per sixteenth of a bit
  // ------------------------------------------------------------
  // Bit time is 4*(baud+1) clocks; a sixteenth of that is (baud+1)/4,
  // so divisors below 3 are clamped to one clock per tick.
  assign divPlus    = {1'b0, sQ.baud} + 17'h00001;
  assign tickLen    = divPlus[16:2];
  assign tickReload = (tickLen == 15'h0000) ? 16'h0000 : {1'b0, tickLen - 15'h0001};
  assign tick = (sQ.tickCnt == 16'h0000);

  assign fifoPop = regRd && regAddr == `RX_REG_DATA;
  assign pushChar.data = sQ.shift;
  assign pushChar.framing = !majority;

  // ------------------------------------------------------------
  // State update
  // ------------------------------------------------------------
  always_comb begin
    sD = sQ;
    fifoPush = 1'b0;
    sD.rxPrev = rxPin;
    if (tick || sQ.state == uart_rx_pkg::RX_IDLE) begin
      sD.tickCnt = tickReload;
    end else begin
      sD.tickCnt = sQ.tickCnt - 16'h0001;
    end
    if (tick) begin
      sD.phase = sQ.phase + 4'h1;
      sD.votes = {sQ.votes[1:0], rxPin};
    end
    case (sQ.state)
      uart_rx_pkg::RX_IDLE: begin
        if (active && !sQ.overrun && sQ.rxPrev && !rxPin) begin
          sD.state = uart_rx_pkg::RX_START;
          sD.phase = 4'h0;
        end
      end
      uart_rx_pkg::RX_START: begin
        if (tick && sQ.phase == 4'(`OVERSAMPLE / 2 - 1)) begin
          sD.phase = 4'h0;
          sD.bitCnt = 4'h0;
          sD.state = rxPin ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
        end
      end
      uart_rx_pkg::RX_DATA: begin
        if (tick && sQ.phase == 4'(`OVERSAMPLE - 1)) begin
          sD.shift = sQ.ctrl[`CTRL_NINE] ? {majority, sQ.shift[8:1]} : {1'b0, majority, sQ.shift[7:1]};
          sD.bitCnt = sQ.bitCnt + 4'h1;
          if (sQ.bitCnt == (sQ.ctrl[`CTRL_NINE] ? 4'h8 : 4'h7)) begin
            sD.state = uart_rx_pkg::RX_STOP;
          end
        end
      end
      uart_rx_pkg::RX_STOP: begin
        if (tick && sQ.phase == 4'(`OVERSAMPLE - 1)) begin
          sD.state = uart_rx_pkg::RX_IDLE;
          if (fifoFull) begin
            sD.overrun = 1'b1;
          end else begin
            fifoPush = 1'b1;
          end
        end
      end
      default: sD.state = uart_rx_pkg::RX_IDLE;
    endcase

    // --------------------------------------------------------
    // Register port
    // --------------------------------------------------------
    if (regWr) begin
      case (regAddr)
        `RX_REG_CTRL:  sD.ctrl = regWdata[5:0];
        `RX_REG_BAUD:  sD.baud = regWdata;
        `RX_REG_IRQEN: sD.irqEn = regWdata[2:0];
        default: ;
      endcase
    end
    sD.rdata = 16'h0000;
    if (regRd) begin
      case (regAddr)
        `RX_REG_CTRL:   sD.rdata = {10'h000, sQ.ctrl};
        `RX_REG_BAUD:   sD.rdata = sQ.baud;
        `RX_REG_IRQEN:  sD.rdata = {13'h0000, sQ.irqEn};
        `RX_REG_DATA: begin
          sD.rdata = {7'h00, headChar.data};
          sD.framing = headChar.framing;
          sD.ninth = headChar.data[8];
        end
        `RX_REG_STATUS: sD.rdata = {12'h000, sQ.ninth, sQ.framing, sQ.overrun, pending};
        default:        sD.rdata = 16'h0000;
      endcase
    end
    if (!sQ.ctrl[`CTRL_RX_EN]) begin
      sD.state = uart_rx_pkg::RX_IDLE;
      sD.overrun = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sQ.ctrl    <= `CTRL_RESET;
      sQ.baud    <= `BAUD_RESET;
      sQ.irqEn   <= 3'h0;
      sQ.state   <= uart_rx_pkg::RX_IDLE;
      sQ.tickCnt <= 16'h0000;
      sQ.phase   <= 4'h0;
      sQ.bitCnt  <= 4'h0;
      sQ.shift   <= 9'h000;
      sQ.votes   <= 3'h7;
      sQ.rxPrev  <= 1'b1;
      sQ.overrun <= 1'b0;
      sQ.framing <= 1'b0;
      sQ.ninth   <= 1'b0;
      sQ.rdata   <= 16'h0000;
    end else begin
      sQ.ctrl    <= sD.ctrl;
      sQ.baud    <= sD.baud;
      sQ.irqEn   <= sD.irqEn;
      sQ.state   <= sD.state;
      sQ.tickCnt <= sD.tickCnt;
      sQ.phase   <= sD.phase;
      sQ.bitCnt  <= sD.bitCnt;
      sQ.shift   <= sD.shift;
      sQ.votes   <= sD.votes;
      sQ.rxPrev  <= sD.rxPrev;
      sQ.overrun <= sD.overrun;
      sQ.framing <= sD.framing;
      sQ.ninth   <= sD.ninth;
      sQ.rdata   <= sD.rdata;
    end
  end

  assign regRdata = sQ.rdata;

  // ------------------------------------------------------------
  // Character store
  // ------------------------------------------------------------
  uart_rx_fifo #(
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rstN     (rstN),
    .flush    (!sQ.ctrl[`CTRL_RX_EN]),
    .push     (fifoPush),
    .pushData (pushChar),
    .pop      (fifoPop),
    .headQ    (headChar),
    .full     (fifoFull),
    .empty    (fifoEmpty)
  );

endmodule : async_uart_receiver

`default_nettype wire

/* File: test/uart_rx_properties.sv */
// Port-level assertions for the serial receiver
`timescale 1ns/10ps
`default_nettype none
module uart_rx_properties (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        rxPin,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  input wire logic        rxIrq
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_quiet: assert property (!regRd |=> regRdata == 16'h0000)
    else $error("read data not zero");
  chk_unmapped_zero: assert property (regRd && regAddr > 4'h4 |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_irq_mask: assert property (regWr && regAddr == 4'h4 && regWdata[2:0] != 3'h7 |-> ##2 !rxIrq)
    else $error("irq with enable off");
  chk_mode_gate: assert property (regWr && regAddr == 4'h0 && regWdata[2:0] != 3'h5 |-> ##3 !rxIrq)
    else $error("irq with receiver off");
  chk_pend_seen: assert property (regRd && regAddr == 4'h3 && rxIrq |=> regRdata[0])
    else $error("pending not shown");
  chk_disable_clears: assert property (regWr && regAddr == 4'h0 && !regWdata[0] ##3 regRd && regAddr == 4'h3
    |=> regRdata[1:0] == 2'h0)
    else $error("overrun survived disable");
  chk_ctrl_back: assert property (regWr && regAddr == 4'h0 ##1 regRd && regAddr == 4'h0
    |=> regRdata[5:0] == $past(regWdata[5:0], 2))
    else $error("control readback");
  chk_baud_back: assert property (regWr && regAddr == 4'h1 ##1 regRd && regAddr == 4'h1
    |=> regRdata == $past(regWdata, 2))
    else $error("divisor readback");
  cov_irq: cover property (rxIrq);
  cov_pop: cover property (regRd && regAddr == 4'h2 && rxIrq);
  cov_start: cover property ($fell(rxPin));
endmodule : uart_rx_properties
bind async_uart_receiver uart_rx_properties chk (.clk(clk), .rst_n(rst_n), .rxPin(rxPin), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxIrq(rxIrq));
`default_nettype wire

/* File: test/uart_line_model.sv */
// Remote transmitter model driving the receive line
`timescale 1ns/10ps
`default_nettype none
module uart_line_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  output var  logic line
);
  // ----
  // Frames, low bit first
  // ----
  initial line = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input logic stopV);
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= d[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line <= stopV;
    repeat (BIT_CLKS) @(posedge clk);
    line <= 1'b1;
    // One idle clock so a following frame never re-drives the line in this step
    @(posedge clk);
    #1;
  endtask : send
  // Short low pulse, released before the start-bit centre
  task automatic glitch(input int w);
    line <= 1'b0;
    repeat (w) @(posedge clk);
    line <= 1'b1;
  endtask : glitch
endmodule : uart_line_model
`default_nettype wire

/* File: test/async_uart_receiver_bench.sv */
// Self-checking bench for the serial receiver
`timescale 1ns/10ps
`default_nettype none
module async_uart_receiver_bench;
  // Divisor 3 gives 16 clocks a bit
  localparam int BITC = 16;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rxPin;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  logic        rxIrq;
  logic [15:0] v;
  int          miscompares = 0;
  int          checks_done = 0;
  always #2 clk = ~clk;
  uart_line_model #(.BIT_CLKS(BITC)) far (.clk(clk), .line(rxPin));
  async_uart_receiver dut (.clk(clk), .rst_n(rst_n), .rxPin(rxPin), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxIrq(rxIrq));
  // ----
  // Bus and compare helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd
  task automatic results;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // ----
  // Scenarios
  // ----
  task automatic t_setup;
    rd(4'h0, v);
    chk(v, 16'h0000);
    wr(4'h1, 16'h0003);
    rd(4'h1, v);
    chk(v, 16'h0003);
    wr(4'h0, 16'h0005);
    rd(4'h0, v);
    chk(v, 16'h0005);
    wr(4'h4, 16'h0007);
    rd(4'h9, v);
    chk(v, 16'h0000);
  endtask : t_setup
  task automatic t_plain;
    far.send(9'h0A5, 8, 1'b1);
    chk({15'h0000, rxIrq}, 16'h0001);
    wr(4'h4, 16'h0003);
    wr(4'h3, 16'h0000);
    chk({15'h0000, rxIrq}, 16'h0000);
    rd(4'h3, v);
    chk(v & 16'h0001, 16'h0001);
    wr(4'h4, 16'h0007);
    rd(4'h2, v);
    chk(v, 16'h00A5);
    rd(4'h3, v);
    chk(v & 16'h0007, 16'h0000);
  endtask : t_plain
  task automatic t_glitch;
    far.glitch(4);
    repeat (12 * BITC) @(posedge clk);
    #1;
    rd(4'h3, v);
    chk(v & 16'h0003, 16'h0000);
    far.send(9'h03C, 8, 1'b0);
    rd(4'h2, v);
    chk(v, 16'h003C);
    rd(4'h3, v);
    chk(v & 16'h0004, 16'h0004);
  endtask : t_glitch
  task automatic t_overrun;
    far.send(9'h011, 8, 1'b1);
    far.send(9'h022, 8, 1'b1);
    far.send(9'h033, 8, 1'b1);
    rd(4'h3, v);
    chk(v & 16'h0003, 16'h0003);
    far.send(9'h044, 8, 1'b1);
    rd(4'h2, v);
    chk(v, 16'h0011);
    rd(4'h2, v);
    chk(v, 16'h0022);
    rd(4'h3, v);
    chk(v & 16'h0003, 16'h0002);
    wr(4'h0, 16'h0004);
    repeat (2) @(posedge clk);
    rd(4'h3, v);
    chk(v & 16'h0003, 16'h0000);
  endtask : t_overrun
  task automatic t_mode;
    wr(4'h0, 16'h0007);
    far.send(9'h055, 8, 1'b1);
    rd(4'h3, v);
    chk(v & 16'h0001, 16'h0000);
    wr(4'h0, 16'h000D);
    far.send(9'h1C3, 9, 1'b1);
    rd(4'h2, v);
    chk(v, 16'h01C3);
  endtask : t_mode
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_setup();
    t_plain();
    t_glitch();
    t_overrun();
    t_mode();
    results();
  end
endmodule : async_uart_receiver_bench
`default_nettype wire
